// ==== inc/nac_regs.svh ====
// Offsets, field positions, reset values and threshold counts of the network access control block.
// Assumes it is included by bare name wherever these constants are needed.
`ifndef NAC_REGS_SVH
`define NAC_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define NAC_OFS_CTRL 12'h030
`define NAC_OFS_STAT 12'h034

// ----------------------------------------------------------------------------
// Field positions of the control register
// ----------------------------------------------------------------------------
`define NAC_FULL_FRAME_BIT 21
`define NAC_LVL_HI 15
`define NAC_LVL_LO 14
`define NAC_TX_RUN_BIT 13
`define NAC_COLLIDE_BIT 12
`define NAC_MODE_HI 11
`define NAC_MODE_LO 10
`define NAC_GROUP_BIT 7
`define NAC_ANY_BIT 6
`define NAC_HOLD_BIT 5
`define NAC_ERRPASS_BIT 3
`define NAC_RX_RUN_BIT 1

// ----------------------------------------------------------------------------
// Reset value and writable-bit mask
// ----------------------------------------------------------------------------
`define NAC_CTRL_RESET 32'h0000_0040
`define NAC_CTRL_MASK 32'h0020_FCEA

// ----------------------------------------------------------------------------
// Start thresholds in bytes at 100 and 10 Mbps
// ----------------------------------------------------------------------------
`define NAC_THR100_0 11'h080
`define NAC_THR100_1 11'h100
`define NAC_THR100_2 11'h200
`define NAC_THR100_3 11'h400
`define NAC_THR10_0 11'h048
`define NAC_THR10_1 11'h060
`define NAC_THR10_2 11'h080
`define NAC_THR10_3 11'h0A0

`endif

// ==== inc/nac_pkg.sv ====
// Types shared by the network access control block.
// Assumes the constants header is compiled alongside it.
package nac_pkg;

  // ----------------------------------------------------------------------------
  // Operating mode codes
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    NAC_MODE_NORMAL = 2'h0,
    NAC_MODE_MAC_LOOP = 2'h1,
    NAC_MODE_RSVD2 = 2'h2,
    NAC_MODE_RSVD3 = 2'h3
  } nac_mode_e;

  // ----------------------------------------------------------------------------
  // Processor states
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    NAC_TX_STOP = 3'h1,
    NAC_TX_WAIT = 3'h2,
    NAC_TX_SEND = 3'h4
  } nac_tx_state_e;

  typedef enum logic [3:0] {
    NAC_RX_STOP = 4'h1,
    NAC_RX_RUN = 4'h2,
    NAC_RX_SUSP = 4'h4,
    NAC_RX_DRAIN = 4'h8
  } nac_rx_state_e;

  // ----------------------------------------------------------------------------
  // Received frame summary, valid with its end strobe
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic addr_match;
    logic multicast;
    logic bad;
    logic pause;
    logic wakeup;
  } nac_rx_info_s;

endpackage : nac_pkg

// ==== design/nac_ctrl.sv ====
// Network access control register with the MAC behaviour it governs.
// Assumes an APB master on pclk, MAC datapath logic on the same clock and a carrier pin from the PHY.
`timescale 1ns/1ps
`include "nac_regs.svh"

module nac_ctrl #(
  parameter int BACKOFF_W = 10,
  parameter int LEVEL_W = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic speed_100,
  input wire logic [LEVEL_W-1:0] tx_fifo_bytes,
  input wire logic tx_whole_frame,
  input wire logic tx_frame_done,
  output logic tx_start,
  output logic tx_active,
  output logic collision_force,
  output logic mac_loopback,
  input wire logic carrier_pin,
  input wire logic backoff_load,
  input wire logic [BACKOFF_W-1:0] backoff_slots,
  input wire logic slot_tick,
  output logic backoff_done,
  input wire logic rx_busy,
  input wire logic rx_suspend,
  input wire logic rx_resume,
  input wire logic rx_frame_end,
  input wire nac_pkg::nac_rx_info_s rx_info,
  input wire logic pause_enable,
  input wire logic wakeup_enable,
  output logic rx_accept,
  output logic rx_discard,
  output logic rx_running
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic wr_ctrl;
  logic rd_hit;
  logic [31:0] stat;
  logic carrier_meta;
  logic carrier_sync;
  logic [BACKOFF_W-1:0] backoff_cnt;
  logic backoff_busy;
  logic [LEVEL_W-1:0] tx_level;
  logic tx_ready;
  logic rx_keep;
  nac_pkg::nac_tx_state_e tx_state;
  nac_pkg::nac_tx_state_e next_tx_state;
  nac_pkg::nac_rx_state_e rx_state;
  nac_pkg::nac_rx_state_e next_rx_state;
  nac_pkg::nac_mode_e mode;

  // Maps the level select and speed onto a start threshold in bytes.
  function automatic logic [10:0] nac_threshold(input logic [1:0] sel, input logic fast);
    logic [10:0] thr;
    thr = 11'h000;
    unique case (sel)
      2'h0: thr = fast ? `NAC_THR100_0 : `NAC_THR10_0;
      2'h1: thr = fast ? `NAC_THR100_1 : `NAC_THR10_1;
      2'h2: thr = fast ? `NAC_THR100_2 : `NAC_THR10_2;
      2'h3: thr = fast ? `NAC_THR100_3 : `NAC_THR10_3;
    endcase
    return thr;
  endfunction : nac_threshold

  // ----------------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------------

  // Every access completes in its first access cycle; unmapped offsets answer with an error.
  assign pready = 1'b1;
  assign rd_hit = (paddr == `NAC_OFS_CTRL) || (paddr == `NAC_OFS_STAT);
  assign pslverr = psel && penable && !rd_hit;
  assign wr_ctrl = psel && penable && pwrite && (paddr == `NAC_OFS_CTRL);

  // Status word shows both processor states and the back-off activity.
  assign stat = {24'h000000, backoff_busy, rx_state, tx_state};

  // Next control value; only implemented bits take a write.
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = pwdata & `NAC_CTRL_MASK;
    end
  end

  // Control register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `NAC_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Read data is registered in the setup cycle so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `NAC_OFS_CTRL) begin
        prdata <= ctrl & `NAC_CTRL_MASK;
      end else if (paddr == `NAC_OFS_STAT) begin
        prdata <= stat;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Mode and test controls
  // ----------------------------------------------------------------------------

  // Reserved mode codes fall back to normal operation; the transceiver loop-back setting is not consulted.
  assign mode = nac_pkg::nac_mode_e'(next_ctrl[`NAC_MODE_HI:`NAC_MODE_LO]);

  // With the collide bit set, a forced collision is raised for the whole of every transmission.
  // Both outputs come from next values, so they change at the same edge as the register and the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_loopback <= 1'b0;
      collision_force <= 1'b0;
    end else begin
      mac_loopback <= (mode == nac_pkg::NAC_MODE_MAC_LOOP);
      collision_force <= next_ctrl[`NAC_COLLIDE_BIT] && (next_tx_state == nac_pkg::NAC_TX_SEND);
    end
  end

  // ----------------------------------------------------------------------------
  // Transmit start control
  // ----------------------------------------------------------------------------

  // Start condition: a whole frame in full-frame mode, otherwise the selected level or a whole frame.
  assign tx_level = LEVEL_W'(nac_threshold(ctrl[`NAC_LVL_HI:`NAC_LVL_LO], speed_100));
  assign tx_ready = ctrl[`NAC_FULL_FRAME_BIT] ? tx_whole_frame :
                    (tx_fifo_bytes >= tx_level) || tx_whole_frame;

  // Transmit processor next state; a frame in flight always completes before stopping.
  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      nac_pkg::NAC_TX_STOP: begin
        if (ctrl[`NAC_TX_RUN_BIT]) begin
          next_tx_state = nac_pkg::NAC_TX_WAIT;
        end
      end
      nac_pkg::NAC_TX_WAIT: begin
        if (!ctrl[`NAC_TX_RUN_BIT]) begin
          next_tx_state = nac_pkg::NAC_TX_STOP;
        end else if (tx_ready) begin
          next_tx_state = nac_pkg::NAC_TX_SEND;
        end
      end
      nac_pkg::NAC_TX_SEND: begin
        if (tx_frame_done) begin
          next_tx_state = ctrl[`NAC_TX_RUN_BIT] ? nac_pkg::NAC_TX_WAIT : nac_pkg::NAC_TX_STOP;
        end
      end
      default: next_tx_state = nac_pkg::NAC_TX_STOP;
    endcase
  end

  // Transmit state register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= nac_pkg::NAC_TX_STOP;
    end else begin
      tx_state <= next_tx_state;
    end
  end

  // Start pulse is registered on the move into sending.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_start <= 1'b0;
    end else begin
      tx_start <= (tx_state == nac_pkg::NAC_TX_WAIT) && (next_tx_state == nac_pkg::NAC_TX_SEND);
    end
  end

  // Sending flag is registered from the next state, so it rises together with the start pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_active <= 1'b0;
    end else begin
      tx_active <= (next_tx_state == nac_pkg::NAC_TX_SEND);
    end
  end

  // ----------------------------------------------------------------------------
  // Back-off counter
  // ----------------------------------------------------------------------------

  // Carrier comes from the PHY and is synchronised before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_meta <= 1'b0;
      carrier_sync <= 1'b0;
    end else begin
      carrier_meta <= carrier_pin;
      carrier_sync <= carrier_meta;
    end
  end

  // Counts slot ticks down to zero; with hold set, carrier freezes the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backoff_cnt <= '0;
      backoff_busy <= 1'b0;
      backoff_done <= 1'b0;
    end else begin
      backoff_done <= 1'b0;
      if (backoff_load) begin
        backoff_cnt <= backoff_slots;
        backoff_busy <= 1'b1;
      end else if (backoff_busy && slot_tick && !(ctrl[`NAC_HOLD_BIT] && carrier_sync)) begin
        if (backoff_cnt == '0) begin
          backoff_busy <= 1'b0;
          backoff_done <= 1'b1;
        end else begin
          backoff_cnt <= backoff_cnt - 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Receive processor
  // ----------------------------------------------------------------------------

  // Receive next state; a clear only acts from running or suspended and lets the frame finish.
  always_comb begin
    next_rx_state = rx_state;
    unique case (rx_state)
      nac_pkg::NAC_RX_STOP: begin
        if (ctrl[`NAC_RX_RUN_BIT]) begin
          next_rx_state = nac_pkg::NAC_RX_RUN;
        end
      end
      nac_pkg::NAC_RX_RUN: begin
        if (!ctrl[`NAC_RX_RUN_BIT]) begin
          next_rx_state = (rx_busy && !rx_frame_end) ? nac_pkg::NAC_RX_DRAIN : nac_pkg::NAC_RX_STOP;
        end else if (rx_suspend) begin
          next_rx_state = nac_pkg::NAC_RX_SUSP;
        end
      end
      nac_pkg::NAC_RX_SUSP: begin
        if (!ctrl[`NAC_RX_RUN_BIT]) begin
          next_rx_state = (rx_busy && !rx_frame_end) ? nac_pkg::NAC_RX_DRAIN : nac_pkg::NAC_RX_STOP;
        end else if (rx_resume) begin
          next_rx_state = nac_pkg::NAC_RX_RUN;
        end
      end
      nac_pkg::NAC_RX_DRAIN: begin
        if (rx_frame_end || !rx_busy) begin
          next_rx_state = nac_pkg::NAC_RX_STOP;
        end
      end
      default: next_rx_state = nac_pkg::NAC_RX_STOP;
    endcase
  end

  // Receive state register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= nac_pkg::NAC_RX_STOP;
    end else begin
      rx_state <= next_rx_state;
    end
  end

  // Running flag is registered from the next state, so it follows the state register exactly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_running <= 1'b0;
    end else begin
      rx_running <= (next_rx_state != nac_pkg::NAC_RX_STOP);
    end
  end

  // ----------------------------------------------------------------------------
  // Receive filter
  // ----------------------------------------------------------------------------

  // Decides acceptance of a finished frame from the filter bits and the processor state.
  always_comb begin
    rx_keep = 1'b0;
    if (rx_info.pause && pause_enable) begin
      rx_keep = 1'b1;
    end else if (rx_info.wakeup && wakeup_enable) begin
      rx_keep = 1'b1;
    end else if (rx_state == nac_pkg::NAC_RX_RUN || rx_state == nac_pkg::NAC_RX_DRAIN) begin
      if (rx_info.bad && !ctrl[`NAC_ERRPASS_BIT]) begin
        rx_keep = 1'b0;
      end else if (ctrl[`NAC_ANY_BIT]) begin
        rx_keep = 1'b1;
      end else if (rx_info.multicast && ctrl[`NAC_GROUP_BIT]) begin
        rx_keep = 1'b1;
      end else begin
        rx_keep = rx_info.addr_match;
      end
    end
  end

  // Verdict pulses follow the frame end strobe by one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_accept <= 1'b0;
      rx_discard <= 1'b0;
    end else begin
      rx_accept <= rx_frame_end && rx_keep;
      rx_discard <= rx_frame_end && !rx_keep;
    end
  end

endmodule : nac_ctrl

// ==== sim/nac_ctrl_sva.sv ====
// Port-level checks of the network access control block.
// Assumes it is bound into nac_ctrl, one clock pclk and active-low reset presetn.
`timescale 1ns/1ps
module nac_ctrl_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic tx_start,
  input wire logic tx_active,
  input wire logic collision_force,
  input wire logic mac_loopback,
  input wire logic rx_frame_end,
  input wire nac_pkg::nac_rx_info_s rx_info,
  input wire logic pause_enable,
  input wire logic rx_accept,
  input wire logic rx_discard,
  input wire logic rx_running
);
  // ----------------------------------------------------------------------------
  // Clocking and bus sequences
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Last collision bit written, tracked from the bus itself.
  logic coll_bit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coll_bit <= 1'b0;
    end else if (psel && penable && pwrite && paddr == 12'h030) begin
      coll_bit <= pwdata[12];
    end
  end
  // Bus phases aimed at the control word.
  sequence s_wr;
    psel && penable && pwrite && paddr == 12'h030;
  endsequence
  sequence s_rd;
    psel && !penable && !pwrite && paddr == 12'h030;
  endsequence
  sequence s_run_on;
    s_wr ##0 pwdata[1];
  endsequence
  // Each check ties an output to its cause.
  property p_ans;
    rx_frame_end |=> rx_accept ^ rx_discard;
  endproperty
  a_ans: assert property (p_ans) else $error("frame end without one verdict");
  property p_quiet;
    !rx_frame_end |=> !rx_accept && !rx_discard;
  endproperty
  a_quiet: assert property (p_quiet) else $error("verdict without frame end");
  property p_pause;
    rx_frame_end && rx_info.pause && pause_enable |=> rx_accept;
  endproperty
  a_pause: assert property (p_pause) else $error("pause frame dropped");
  property p_loop;
    s_wr |=> mac_loopback == ($past(pwdata[11:10]) == 2'h1);
  endproperty
  a_loop: assert property (p_loop) else $error("loop-back output wrong");
  property p_coll;
    collision_force == (tx_active && coll_bit);
  endproperty
  a_coll: assert property (p_coll) else $error("collision outside a send");
  property p_start;
    tx_start == $rose(tx_active);
  endproperty
  a_start: assert property (p_start) else $error("start pulse misplaced");
  property p_err;
    psel && penable && paddr != 12'h030 && paddr != 12'h034 |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_rsv;
    s_rd |=> (prdata & ~32'h0020_FCEA) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit read as one");
  property p_run;
    s_run_on |-> ##[1:2] rx_running;
  endproperty
  a_run: assert property (p_run) else $error("receive did not start");
endmodule : nac_ctrl_sva

bind nac_ctrl nac_ctrl_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .tx_start(tx_start), .tx_active(tx_active), .collision_force(collision_force),
  .mac_loopback(mac_loopback), .rx_frame_end(rx_frame_end), .rx_info(rx_info),
  .pause_enable(pause_enable), .rx_accept(rx_accept), .rx_discard(rx_discard), .rx_running(rx_running));

// ==== sim/nac_medium.sv ====
// Behavioural network medium seen through the PHY: carrier and received frames.
// Assumes the bench requests a frame with send while no frame is on the line.
`timescale 1ns/1ps
module nac_medium (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  input wire nac_pkg::nac_rx_info_s info,
  input wire logic carrier_on,
  output logic carrier_pin,
  output logic rx_busy,
  output logic rx_frame_end,
  output nac_pkg::nac_rx_info_s rx_info
);
  logic [2:0] cnt;
  nac_pkg::nac_rx_info_s held;
  assign carrier_pin = carrier_on;
  // A frame holds the line four cycles; its summary is only valid with the end strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      rx_busy <= 1'b0;
      rx_frame_end <= 1'b0;
      rx_info <= 5'h0A;
      held <= 5'h00;
    end else if (send && !rx_busy) begin
      held <= info;
      rx_busy <= 1'b1;
      cnt <= 3'h4;
      rx_frame_end <= 1'b0;
    end else if (rx_busy) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) begin
        rx_busy <= 1'b0;
        rx_frame_end <= 1'b1;
        rx_info <= held;
      end
    end else begin
      rx_frame_end <= 1'b0;
      rx_info <= ~rx_info;
    end
  end
endmodule : nac_medium

// ==== sim/nac_ctrl_bench.sv ====
// Self-checking bench of the network access control block.
// Assumes the design, its header and package, the checker and the medium model are compiled.
`timescale 1ns/1ps
`include "nac_regs.svh"
module nac_ctrl_bench;
  logic pclk, presetn, psel, penable, pwrite, speed_100, tx_whole_frame, tx_frame_done, backoff_load;
  logic slot_tick, pause_enable, wakeup_enable, send, carrier_on, carrier_pin, rx_busy, rx_frame_end, rx_suspend;
  logic pready, pslverr, tx_start, tx_active, collision_force, mac_loopback, backoff_done;
  logic rx_accept, rx_discard, rx_running;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [10:0] tx_fifo_bytes;
  logic [9:0] backoff_slots;
  nac_pkg::nac_rx_info_s rx_info, info;
  logic [31:0] exp_rd[$];
  logic [1:0] exp_rx[$];
  logic exp_err[$];
  logic [10:0] thr_tab [8] = '{`NAC_THR10_0, `NAC_THR10_1, `NAC_THR10_2, `NAC_THR10_3,
    `NAC_THR100_0, `NAC_THR100_1, `NAC_THR100_2, `NAC_THR100_3};
  int err_count = 0, checked = 0, cyc = 0, n_done = 0;

  nac_ctrl i_nac_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_100(speed_100), .tx_fifo_bytes(tx_fifo_bytes), .tx_whole_frame(tx_whole_frame),
    .tx_frame_done(tx_frame_done), .tx_start(tx_start), .tx_active(tx_active),
    .collision_force(collision_force), .mac_loopback(mac_loopback), .carrier_pin(carrier_pin),
    .backoff_load(backoff_load), .backoff_slots(backoff_slots), .slot_tick(slot_tick),
    .backoff_done(backoff_done), .rx_busy(rx_busy), .rx_suspend(rx_suspend), .rx_resume(1'b0),
    .rx_frame_end(rx_frame_end), .rx_info(rx_info), .pause_enable(pause_enable),
    .wakeup_enable(wakeup_enable), .rx_accept(rx_accept), .rx_discard(rx_discard), .rx_running(rx_running));
  nac_medium i_nac_medium (.pclk(pclk), .presetn(presetn), .send(send), .info(info), .carrier_on(carrier_on),
    .carrier_pin(carrier_pin), .rx_busy(rx_busy), .rx_frame_end(rx_frame_end), .rx_info(rx_info));

  // Clock of 20 ns period.
  always #10 pclk = ~pclk;

  task cmp(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  task results();
    $display("counts: %0d mismatches, %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // One bus transfer: setup, then access held until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    exp_err.push_back(a != `NAC_OFS_CTRL && a != `NAC_OFS_STAT);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Expected verdict {accept, discard}: r holds the frame summary, then pause and wake-up enables.
  function automatic logic [1:0] rx_exp(input logic [31:0] c, input logic [6:0] r);
    if ((r[1] && r[5]) || (r[0] && r[6])) return 2'b10;
    if (!c[1] || (r[2] && !c[3])) return 2'b01;
    if (c[6] || (r[3] && c[7])) return 2'b10;
    return {r[4], !r[4]};
  endfunction : rx_exp

  // Watcher: takes the oldest note whenever read data or a verdict appears; also cuts hangs.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite) cmp(exp_rd.pop_front(), prdata);
    if (psel && penable && !pwrite) cmp({31'h0, exp_err.pop_front()}, {31'h0, pslverr});
    if ((rx_accept | rx_discard) !== 1'b0) cmp({30'h0, exp_rx.pop_front()}, {30'h0, rx_accept, rx_discard});
    if (backoff_done === 1'b1) n_done++;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  // Main sequence.
  initial begin
    int i, n;
    logic [31:0] c, p, r;
    logic [10:0] thr;
    {pclk, presetn, psel, penable, pwrite, speed_100, tx_whole_frame, tx_frame_done} = 8'h00;
    {backoff_load, slot_tick, pause_enable, wakeup_enable, send, carrier_on, rx_suspend} = 7'h00;
    p = 32'h0;
    {paddr, pwdata, tx_fifo_bytes, backoff_slots, info} = 0;
    r = $urandom(82172);
    tick(10);
    presetn <= 1'b1;
    rd(12'h030, `NAC_CTRL_RESET);
    apb(1'b1, 12'h030, 32'hFFFF_F3FF);
    rd(12'h030, 32'h0020_F0EA);
    rd(12'h03C, 32'h0);
    apb(1'b1, 12'h030, 32'h0020_D0E8);
    apb(1'b1, 12'h030, 32'h0);
    $display("test registers done");
    for (i = 0; i < 24; i++) begin
      c = $urandom & 32'hCA;
      r = $urandom;
      info <= r[4:0];
      pause_enable <= r[5];
      wakeup_enable <= r[6];
      apb(1'b1, 12'h030, p & ~32'h2);
      apb(1'b1, 12'h030, c & ~32'h2);
      apb(1'b1, 12'h030, c);
      p = c;
      tick(2);
      exp_rx.push_back(rx_exp(c, r[6:0]));
      send <= 1'b1;
      tick(1);
      send <= 1'b0;
      tick(8);
    end
    apb(1'b1, 12'h030, p & ~32'h2);
    apb(1'b1, 12'h030, 32'h0);
    $display("test receive filter done");
    for (i = 0; i < 9; i++) begin
      c = {16'h0, i[1:0], 14'h0} | (i == 8 ? 32'h0020_0000 : 32'h0) | (i[0] ? 32'h1400 : 32'h0);
      thr = thr_tab[i[2:0]];
      speed_100 <= i[2];
      tx_fifo_bytes <= (i == 8) ? 11'h7FF : thr - 11'h1;
      tx_whole_frame <= 1'b0;
      apb(1'b1, 12'h030, c);
      apb(1'b1, 12'h030, c | 32'h2000);
      tick(6);
      cmp(32'h0, {31'h0, tx_active});
      if (i == 8) tx_whole_frame <= 1'b1;
      else tx_fifo_bytes <= thr;
      n = 0;
      while (tx_start !== 1'b1 && n < 20) begin
        tick(1);
        n++;
      end
      cmp({29'h0, 1'b1, i[0], i[0]}, {29'h0, tx_start, collision_force, mac_loopback});
      apb(1'b1, 12'h030, c);
      tx_frame_done <= 1'b1;
      tick(1);
      tx_frame_done <= 1'b0;
      tick(3);
      cmp(32'h0, {31'h0, tx_active});
    end
    $display("test transmit done");
    apb(1'b1, 12'h030, 32'h20);
    carrier_on <= 1'b1;
    backoff_slots <= 10'h2;
    backoff_load <= 1'b1;
    tick(1);
    backoff_load <= 1'b0;
    tick(3);
    repeat (5) begin
      slot_tick <= 1'b1;
      tick(1);
      slot_tick <= 1'b0;
      tick(1);
    end
    cmp(32'h0, n_done);
    carrier_on <= 1'b0;
    tick(3);
    repeat (3) begin
      slot_tick <= 1'b1;
      tick(1);
      slot_tick <= 1'b0;
      tick(1);
    end
    tick(2);
    cmp(32'h1, n_done);
    $display("test back-off done");
    // Receive stop while suspended and busy: the frame drains, is still filtered, then the processor stops.
    apb(1'b1, 12'h030, 32'h62);
    tick(2);
    info <= 5'h10;
    rx_suspend <= 1'b1;
    send <= 1'b1;
    exp_rx.push_back(2'b10);
    tick(1);
    rx_suspend <= 1'b0;
    send <= 1'b0;
    apb(1'b1, 12'h030, 32'h60);
    tick(2);
    cmp(32'h1, {31'h0, rx_running});
    tick(3);
    cmp(32'h0, {31'h0, rx_running});
    rd(12'h034, 32'h0000_0009);
    $display("test receive stop done");
    results();
  end
endmodule : nac_ctrl_bench
